// ==== rtl/pmrc_params.svh ====
// Offsets, field positions, reset values and times of the mode controller
`ifndef PMRC_PARAMS_SVH
`define PMRC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMRC_OFF_CMD      8'h00
`define PMRC_OFF_CFG      8'h04
`define PMRC_OFF_FLT      8'h08
`define PMRC_OFF_STAT     8'h0C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PMRC_CMD_OFF      0
`define PMRC_CMD_SLP      1
`define PMRC_CMD_SRST     2
`define PMRC_CFG_W        6
`define PMRC_CFG_IDLE_EN  0
`define PMRC_CFG_IDLE_OFF 1
`define PMRC_CFG_SLPT_LO  2
`define PMRC_CFG_SLPT_HI  4
`define PMRC_CFG_BAL_OFF  5
`define PMRC_CFG_RST      6'h00
`define PMRC_FLT_W        4
`define PMRC_FLT_DIGITAL_RESET_FLAG     0
`define PMRC_FLT_FCOMM    1
`define PMRC_FLT_CCLR     2
`define PMRC_FLT_STOP     3
`define PMRC_FLT_RST      4'h0
`define PMRC_STAT_BUSY    2

// ----------------------------------------------------------------
// Times in ns and clock period
// ----------------------------------------------------------------
`define PMRC_CLK_NS       4
`define PMRC_HWRST_NS     40000
`define PMRC_IDLE_NS      1000000
`define PMRC_SLPU_NS      1000000

`endif

// ==== rtl/pmrc_pkg.sv ====
// Types shared by the power-mode and reset controller
package pmrc_pkg;

	typedef enum logic [1:0] {
		PMRC_SHDN,
		PMRC_SLEEP,
		PMRC_ACTIVE,
		PMRC_HOFF
	} pmrc_mode_t;

	typedef struct packed {
		pmrc_mode_t  mode;
		logic [31:0] cnt;
		logic        ap_act;
		logic        ap_wr;
		logic [7:0]  ap_addr;
		logic [31:0] rdata;
		logic        rdy;
		logic        resp;
		logic [5:0]  cfg;
		logic [3:0]  flags;
		logic        dig_rst;
		logic        uart_rst;
		logic        fwd_wake;
		logic        fwd_res;
		logic        hb_seen;
		logic        ft_seen;
		logic        lp_en;
		logic        fu_en;
		logic        hr_busy;
	} pmrc_state_t;

endpackage : pmrc_pkg

// ==== rtl/pmrc_ctrl.sv ====
// Power-mode and reset controller with AHB-Lite register slave
//
// Functional notes
// RULE_01: In shutdown only wake ping or tone is heard; it leads to active.
// RULE_02: Base wake from shutdown sets reset, fault-comm, comm-clear flags.
// RULE_03: Stack device sets reset and fault-comm flags; top sets reset only.
// RULE_04: Writing one to the off command puts the device in shutdown.
// RULE_05: Link idle timeout set for shutdown moves active to shutdown.
// RULE_06: Selected low-power timeout moves sleep to shutdown.
// RULE_07: Optional shutdown once all balancing has completed.
// RULE_08: Die overtemperature shuts the device down.
// RULE_09: Shutdown ping or tone forces shutdown without any register access.
// RULE_10: Hard reinit turns all off for a set time; restarts in shutdown.
// RULE_11: In sleep supplies stay on; only limited functions run.
// RULE_12: Sleep is left by wake (with reset) or resume (no reset).
// RULE_13: Sleep is entered from active only, e.g. by the sleep command.
// RULE_14: Link idle timeout set for sleep moves active to sleep.
// RULE_15: Wake from shutdown resets registers and reloads shadow values.
// RULE_16: Wake from sleep resets digital; only the reset flag is set.
// RULE_17: Resume from sleep resets the UART only; base sets comm-clear flag.
// RULE_18: Active wake, soft reset, supply UV or watchdog fault reset digital.
// RULE_19: Resume in active or comm clear resets UART, sets clear and stop.
// RULE_20: UART-only resets touch the base device only.
// RULE_21: Detection of each signal is gated by the current power mode; link_rx_valid clears the timer in every mode, hard reinit included.
// RULE_22: Ping shapes are decoded upstream; events arrive here as pulses.
// RULE_23: Accepted wake and resume are forwarded as tones; others are not.
// RULE_24: Host enables sleep functions in active before entering sleep.
// RULE_25: After power-on reset the controller starts in shutdown.
// RULE_26: Events are one-cycle pulses; hard reinit wins over everything.
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_ctrl
	import pmrc_pkg::*;
#(
	parameter int HWRST_CYC =
		(`PMRC_HWRST_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS,
	parameter int IDLE_CYC  = `PMRC_IDLE_NS / `PMRC_CLK_NS,
	parameter int SLPU_CYC  = `PMRC_SLPU_NS / `PMRC_CLK_NS
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        wake_ping,
	input  wire logic        wake_tone,
	input  wire logic        resume_signal_ping,
	input  wire logic        resume_signal_tone,
	input  wire logic        shdn_ping,
	input  wire logic        shdn_tone,
	input  wire logic        hard_reinit_signal_ping,
	input  wire logic        hard_reinit_signal_tone,
	input  wire logic        heartbeat_tone,
	input  wire logic        fault_tone,
	input  wire logic        comm_clear,
	input  wire logic        link_rx_valid,
	input  wire logic        bal_done,
	input  wire logic        die_overtemp,
	input  wire logic        avdd_uv,
	input  wire logic        dvdd_uv,
	input  wire logic        osc_wdog_fault,
	input  wire logic        is_base,
	input  wire logic        is_top,
	output pmrc_mode_t       mode,
	output logic             digital_reset,
	output logic             uart_reset,
	output logic             fwd_wake_tone,
	output logic             fwd_resume_tone,
	output logic             heartbeat_seen,
	output logic             fault_tone_seen,
	output logic             lowpower_funcs_en,
	output logic             full_funcs_en,
	output logic             hard_reinit_busy
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Flags raised by a wake out of shutdown, by chain position
	function automatic logic [3:0] wake_flags(input logic base,
		input logic top);
		logic [3:0] f;
		f = `PMRC_FLT_RST;
		f[`PMRC_FLT_DIGITAL_RESET_FLAG] = 1'b1;
		f[`PMRC_FLT_FCOMM] = base | ~top;
		f[`PMRC_FLT_CCLR] = base;
		return f;
	endfunction : wake_flags

	function automatic logic [31:0] last_cnt(input int cyc);
		return 32'(cyc - 1);
	endfunction : last_cnt

	localparam pmrc_state_t ST_RST = '{mode: PMRC_SHDN, rdy: 1'b1,
		cfg: `PMRC_CFG_RST, flags: `PMRC_FLT_RST, default: '0};

	pmrc_state_t st_r;
	pmrc_state_t st_nxt;

	logic        in_sd;
	logic        in_sl;
	logic        in_ac;
	logic        awake;
	logic        ev_wake;
	logic        ev_res;
	logic        ev_shd;
	logic        ev_hr;
	logic        ev_supply;
	logic        ev_ot;
	logic        wr_cmd;
	logic        wr_cfg;
	logic        wr_flt;
	logic        cmd_off;
	logic        cmd_slp;
	logic        cmd_srst;
	logic [3:0]  w1c;
	logic [3:0]  fset;
	logic        digital_reset_flag;
	logic [2:0]  slp_sel;
	logic [31:0] slp_lim;
	logic        idle_hit;
	logic        slp_hit;
	logic        hw_done;
	logic        addr_ok;

	// ----------------------------------------------------------------
	// Event gating by power mode
	// ----------------------------------------------------------------
	always_comb begin
		in_sd = st_r.mode == PMRC_SHDN;
		in_sl = st_r.mode == PMRC_SLEEP;
		in_ac = st_r.mode == PMRC_ACTIVE;
		awake = in_sl | in_ac;
		// Ping and tone of one kind act alike [RULE_22]
		// Shutdown listens for wake only [RULE_01] [RULE_21]
		ev_wake = (wake_ping | wake_tone) & (in_sd | awake);
		ev_res = (resume_signal_ping | resume_signal_tone) & awake;
		ev_shd = (shdn_ping | shdn_tone) & awake;
		ev_hr = (hard_reinit_signal_ping | hard_reinit_signal_tone)
			& awake;
		// Supplies are off in shutdown, so undervoltage means nothing
		ev_supply = (avdd_uv | dvdd_uv | osc_wdog_fault) & awake;
		ev_ot = die_overtemp & awake;
	end

	// ----------------------------------------------------------------
	// Bus data phase decode
	// ----------------------------------------------------------------
	always_comb begin
		wr_cmd = st_r.ap_act & st_r.ap_wr & st_r.ap_addr == `PMRC_OFF_CMD;
		wr_cfg = st_r.ap_act & st_r.ap_wr & st_r.ap_addr == `PMRC_OFF_CFG;
		wr_flt = st_r.ap_act & st_r.ap_wr & st_r.ap_addr == `PMRC_OFF_FLT;
		// Commands are heard only while the link is up
		cmd_off = wr_cmd & in_ac & hwdata[`PMRC_CMD_OFF];
		cmd_slp = wr_cmd & in_ac & hwdata[`PMRC_CMD_SLP];
		cmd_srst = wr_cmd & in_ac & hwdata[`PMRC_CMD_SRST];
		w1c = wr_flt ? hwdata[`PMRC_FLT_W-1:0] : `PMRC_FLT_RST;
		addr_ok = hsel & hready & htrans[1];
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	always_comb begin
		slp_sel = st_r.cfg[`PMRC_CFG_SLPT_HI:`PMRC_CFG_SLPT_LO];
		// Each step of the select doubles the sleep time
		slp_lim = 32'(SLPU_CYC) << (slp_sel - 3'h1);
		idle_hit = in_ac & st_r.cfg[`PMRC_CFG_IDLE_EN]
			& st_r.cnt == last_cnt(IDLE_CYC);
		slp_hit = in_sl & slp_sel != 3'h0
			& st_r.cnt == slp_lim - 32'h1;
		hw_done = st_r.mode == PMRC_HOFF
			& st_r.cnt == last_cnt(HWRST_CYC);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.dig_rst = 1'b0;
		st_nxt.uart_rst = 1'b0;
		st_nxt.fwd_wake = 1'b0;
		st_nxt.fwd_res = 1'b0;
		st_nxt.cnt = st_r.cnt + 32'h1;
		fset = `PMRC_FLT_RST;
		digital_reset_flag = 1'b0;

		if (wr_cfg) begin
			st_nxt.cfg = hwdata[`PMRC_CFG_W-1:0];
		end

		if (ev_hr) begin
			st_nxt.mode = PMRC_HOFF; // [RULE_10] [RULE_26]
		end else if (st_r.mode == PMRC_HOFF) begin
			if (hw_done) begin
				// Power-on-like: registers back to reset, no flags
				st_nxt.mode = PMRC_SHDN; // [RULE_10] [RULE_25]
				st_nxt.cfg = `PMRC_CFG_RST;
				st_nxt.flags = `PMRC_FLT_RST;
			end
		end else if (ev_wake) begin
			digital_reset_flag = 1'b1;
			st_nxt.mode = PMRC_ACTIVE; // [RULE_01] [RULE_12]
			st_nxt.fwd_wake = 1'b1; // [RULE_23]
			if (in_sd) begin
				fset = wake_flags(is_base, is_top); // [RULE_02] [RULE_03]
			end else begin
				fset[`PMRC_FLT_DIGITAL_RESET_FLAG] = 1'b1; // [RULE_16] [RULE_18]
			end
		end else if (ev_supply | cmd_srst) begin
			digital_reset_flag = 1'b1;
			fset[`PMRC_FLT_DIGITAL_RESET_FLAG] = 1'b1; // [RULE_18]
		end else if (ev_ot | ev_shd) begin
			st_nxt.mode = PMRC_SHDN; // [RULE_08] [RULE_09]
		end else if (ev_res) begin
			st_nxt.mode = PMRC_ACTIVE; // [RULE_12]
			st_nxt.fwd_res = 1'b1; // [RULE_23]
			st_nxt.uart_rst = is_base; // [RULE_20]
			fset[`PMRC_FLT_CCLR] = is_base; // [RULE_17] [RULE_19]
			fset[`PMRC_FLT_STOP] = is_base & in_ac; // [RULE_19]
		end else if (comm_clear & in_ac) begin
			st_nxt.uart_rst = is_base; // [RULE_19] [RULE_20]
			fset[`PMRC_FLT_CCLR] = is_base;
			fset[`PMRC_FLT_STOP] = is_base;
		end else if (bal_done & awake & st_r.cfg[`PMRC_CFG_BAL_OFF]) begin
			st_nxt.mode = PMRC_SHDN; // [RULE_07]
		end else if (cmd_off) begin
			st_nxt.mode = PMRC_SHDN; // [RULE_04]
		end else if (cmd_slp) begin
			st_nxt.mode = PMRC_SLEEP; // [RULE_13]
		end else if (idle_hit) begin
			// Idle timeout target chosen by config [RULE_05] [RULE_14]
			st_nxt.mode = st_r.cfg[`PMRC_CFG_IDLE_OFF] ? PMRC_SHDN
				: PMRC_SLEEP;
		end else if (slp_hit) begin
			st_nxt.mode = PMRC_SHDN; // [RULE_06]
		end

		// Digital reset: defaults and shadow reload [RULE_15] [RULE_18]
		if (digital_reset_flag) begin
			st_nxt.dig_rst = 1'b1;
			st_nxt.cfg = `PMRC_CFG_RST;
			st_nxt.flags = fset;
		end else if (!(st_r.mode == PMRC_HOFF && hw_done)) begin
			// A set in the same cycle as its clear wins
			st_nxt.flags = (st_r.flags & ~w1c) | fset;
		end

		if (st_nxt.mode != st_r.mode || link_rx_valid) begin
			st_nxt.cnt = 32'h0;
		end

		st_nxt.hb_seen = heartbeat_tone & in_sl; // [RULE_21]
		st_nxt.ft_seen = fault_tone & awake; // [RULE_21]
		st_nxt.lp_en = st_nxt.mode == PMRC_SLEEP
			|| st_nxt.mode == PMRC_ACTIVE; // [RULE_11]
		st_nxt.fu_en = st_nxt.mode == PMRC_ACTIVE; // [RULE_11]
		st_nxt.hr_busy = st_nxt.mode == PMRC_HOFF; // [RULE_10]

		// ----------------------------------------------------------------
		// Bus address phase; read data sampled here
		// ----------------------------------------------------------------
		st_nxt.ap_act = addr_ok;
		st_nxt.ap_wr = hwrite;
		st_nxt.ap_addr = haddr[7:0];
		st_nxt.rdy = 1'b1;
		st_nxt.resp = 1'b0;
		if (addr_ok && !hwrite) begin
			st_nxt.rdata = 32'h0;
			if (haddr[31:8] == 24'h0) begin
				unique case (haddr[7:0])
					`PMRC_OFF_CFG: st_nxt.rdata =
						{{(32-`PMRC_CFG_W){1'b0}}, st_r.cfg};
					`PMRC_OFF_FLT: st_nxt.rdata =
						{{(32-`PMRC_FLT_W){1'b0}}, st_r.flags};
					`PMRC_OFF_STAT: begin
						st_nxt.rdata[1:0] = st_r.mode;
						st_nxt.rdata[`PMRC_STAT_BUSY] =
							st_r.mode == PMRC_HOFF;
					end
					default: st_nxt.rdata = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_RST; // [RULE_25]
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout = st_r.rdy;
	assign hresp = st_r.resp;
	assign hrdata = st_r.rdata;
	assign mode = st_r.mode;
	assign digital_reset = st_r.dig_rst;
	assign uart_reset = st_r.uart_rst;
	assign fwd_wake_tone = st_r.fwd_wake;
	assign fwd_resume_tone = st_r.fwd_res;
	assign heartbeat_seen = st_r.hb_seen;
	assign fault_tone_seen = st_r.ft_seen;
	assign lowpower_funcs_en = st_r.lp_en;
	assign full_funcs_en = st_r.fu_en;
	assign hard_reinit_busy = st_r.hr_busy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic quiet_hi;
	assign quiet_hi = !(wake_ping | wake_tone | shdn_ping | shdn_tone
		| hard_reinit_signal_ping | hard_reinit_signal_tone
		| die_overtemp | avdd_uv | dvdd_uv | osc_wdog_fault);

	sequence s_wake_in_sd;
		ce && in_sd && (wake_ping || wake_tone);
	endsequence
	sequence s_reset_done;
		digital_reset && mode == PMRC_ACTIVE;
	endsequence

	chk_shdn_holds: assert property ( // [RULE_01]
		ce && in_sd && !wake_ping && !wake_tone |=> mode == PMRC_SHDN)
		else $error("shutdown left without wake");
	chk_wake_reset: assert property ( // [RULE_15]
		s_wake_in_sd |=> s_reset_done ##1 !digital_reset || !ce)
		else $error("wake from shutdown did not reset into active");
	chk_base_flags: assert property ( // [RULE_02]
		s_wake_in_sd and is_base |=> st_r.flags[2:0] == 3'b111)
		else $error("base wake flags wrong");
	chk_top_flags: assert property ( // [RULE_03]
		s_wake_in_sd and !is_base && is_top |=> st_r.flags == 4'h1)
		else $error("top-of-stack wake flags wrong");
	chk_hr_first: assert property ( // [RULE_26]
		ce && ev_hr |=> mode == PMRC_HOFF && !digital_reset)
		else $error("hard reinit did not take priority");
	chk_hoff_end: assert property ( // [RULE_10]
		ce && hw_done && !ev_hr |=> mode == PMRC_SHDN
		&& st_r.flags == 4'h0)
		else $error("hard reinit did not end in shutdown");
	chk_sleep_entry: assert property ( // [RULE_13]
		ce && mode != PMRC_SLEEP ##1 mode == PMRC_SLEEP
		|-> $past(mode) == PMRC_ACTIVE)
		else $error("sleep entered from a mode other than active");
	chk_resume_act: assert property ( // [RULE_19]
		ce && in_ac && is_base && resume_signal_ping && quiet_hi
		|=> uart_reset && st_r.flags[3:2] == 2'b11 && fwd_resume_tone)
		else $error("resume in active did not reset uart");
	chk_stack_uart: assert property ( // [RULE_20]
		!is_base |-> !uart_reset)
		else $error("uart reset in a stack device");
	chk_ot_down: assert property ( // [RULE_08]
		ce && ev_ot && !ev_hr && !ev_wake && !ev_supply && !cmd_srst
		|=> mode == PMRC_SHDN && !fwd_wake_tone)
		else $error("overtemperature did not shut down");

endmodule : pmrc_ctrl

// ==== test/pmrc_far_end.sv ====
// Host-side model that registers requests into ping and tone events one cycle later
`timescale 1ns/1ps

module pmrc_far_end (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [11:0] req,
	output logic      [11:0] ev
);
	// ----------------------------------------------------------------
	// Detected pings and tones
	// ----------------------------------------------------------------
	// Pulse shapes are decoded ahead of the controller, so only the
	// resulting event reaches it; the host wakes or resumes a device
	// that cannot be talked to instead of writing to it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ev <= 12'h000;
		end else begin
			ev <= req;
		end
	end
endmodule : pmrc_far_end

// ==== test/power_mode_reset_controller_tb.sv ====
// Self-checking bench of the power-mode and reset controller
`timescale 1ns/1ps
`include "pmrc_params.svh"

module power_mode_reset_controller_tb;
	import pmrc_pkg::*;
	localparam int HW = 8;
	localparam int ID = 16;
	localparam int SL = 8;
	localparam logic [31:0] CM = {24'h000000, `PMRC_OFF_CMD};
	localparam logic [31:0] CF = {24'h000000, `PMRC_OFF_CFG};
	localparam logic [31:0] FL = {24'h000000, `PMRC_OFF_FLT};
	localparam logic [31:0] ST = {24'h000000, `PMRC_OFF_STAT};
	localparam logic [16:0] WP = 17'h00001, WT = 17'h00002, RP = 17'h00004;
	localparam logic [16:0] RT = 17'h00008, SDP = 17'h00010;
	localparam logic [16:0] SDT = 17'h00020, HP = 17'h00040;
	localparam logic [16:0] HT = 17'h00080, HB = 17'h00100, FT = 17'h00200;
	localparam logic [16:0] CC = 17'h00400, LV = 17'h00800;
	localparam logic [16:0] BAL = 17'h01000, OT = 17'h02000;
	localparam logic [16:0] AUV = 17'h04000, DUV = 17'h08000;
	localparam logic [16:0] WD = 17'h10000;
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] e;
	} pmrc_note_t;

	logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        rd_dp = 1'b0, is_base = 1'b1, is_top = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, lf = 32'h1138;
	logic [1:0]  htrans = 2'b00;
	logic [11:0] req = 12'h000;
	logic [11:0] evt;
	logic [4:0]  flt = 5'h00;
	logic        hreadyout, fw, fr, hb, ft;
	logic        ce = 1'b1, lp_en, fu_en, hr_busy;
	logic [31:0] hrdata;
	logic [31:0] n_fw = 0, n_fr = 0, n_hb = 0, n_ft = 0, x_fw = 0, x_fr = 0;
	int          failures = 0, checks = 0;
	pmrc_note_t  q[$];
	pmrc_note_t  nt;
	logic [16:0] drc [4] = '{AUV, DUV, WD, WP};
	logic [16:0] sdc [4] = '{SDP, SDT, OT, BAL};

	always #2 clk = ~clk;

	pmrc_far_end far (.clk(clk), .nrst(nrst), .req(req), .ev(evt));

	pmrc_ctrl #(.HWRST_CYC(HW), .IDLE_CYC(ID), .SLPU_CYC(SL)) dut (
		.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.wake_ping(evt[0]), .wake_tone(evt[1]), .resume_signal_ping(evt[2]),
		.resume_signal_tone(evt[3]), .shdn_ping(evt[4]), .shdn_tone(evt[5]),
		.hard_reinit_signal_ping(evt[6]), .hard_reinit_signal_tone(evt[7]),
		.heartbeat_tone(evt[8]), .fault_tone(evt[9]), .comm_clear(evt[10]),
		.link_rx_valid(evt[11]), .bal_done(flt[0]), .die_overtemp(flt[1]),
		.avdd_uv(flt[2]), .dvdd_uv(flt[3]), .osc_wdog_fault(flt[4]),
		.is_base(is_base), .is_top(is_top), .mode(), .digital_reset(),
		.uart_reset(), .fwd_wake_tone(fw), .fwd_resume_tone(fr),
		.heartbeat_seen(hb), .fault_tone_seen(ft),
		.lowpower_funcs_en(lp_en), .full_funcs_en(fu_en),
		.hard_reinit_busy(hr_busy)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	// Entered just after a rising edge; request held until hready is seen
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		q.push_back('{a, e});
		xfer(a, 1'b0, 32'h0);
	endtask : rd

	task automatic ev(input logic [16:0] m);
		req <= m[11:0];
		flt <= m[16:12];
		if (|m[1:0] && !(|m[7:6])) x_fw = x_fw + 1;
		if (|m[3:2]) x_fr = x_fr + 1;
		@(posedge clk);
		req <= 12'h000;
		flt <= 5'h00;
		repeat (3) @(posedge clk);
	endtask : ev

	// Wake from shutdown, then clear the expected flags
	task automatic up();
		ev(WP);
		wr(FL, 32'hF);
	endtask : up

	// Reinit busy and function enables, looked at once settled
	task automatic pw(input logic [2:0] e);
		chk("hr_lp_fu", {hr_busy, lp_en, fu_en}, e);
	endtask : pw

	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rd_dp && hreadyout === 1'b1) begin
			nt = q.pop_front();
			chk($sformatf("reg_%0h", nt.a), hrdata, nt.e);
		end
		if (fw === 1'b1) n_fw <= n_fw + 1;
		if (fr === 1'b1) n_fr <= n_fr + 1;
		if (hb === 1'b1) n_hb <= n_hb + 1;
		if (ft === 1'b1) n_ft <= n_ft + 1;
	end

	initial begin
		#80000;
		failures++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(ST, 0);
		rd(CF, 0);
		pw(3'b000);
		wr(CM, 2);
		ev(RP | SDP | HB);
		x_fr = x_fr - 1;
		rd(ST, 0);
		for (int i = 0; i < 3; i++) begin
			is_base <= (i == 0);
			is_top <= (i == 2);
			ev(i == 0 ? WP : WT);
			rd(ST, 2);
			rd(FL, 32'h7 >> i);
			wr(FL, 32'hF);
			rd(FL, 0);
			wr(CM, 1);
			rd(ST, 0);
		end
		is_base <= 1'b1;
		is_top <= 1'b0;
		up();
		wr(CM, 2);
		rd(ST, 1);
		pw(3'b010);
		ev(HB | FT);
		ev(RT);
		rd(ST, 2);
		rd(FL, 4);
		pw(3'b011);
		wr(FL, 32'hF);
		wr(CM, 2);
		ev(WT);
		rd(ST, 2);
		rd(FL, 1);
		wr(FL, 32'hF);
		ev(RP | HB | FT);
		rd(FL, 32'hC);
		wr(FL, 32'hF);
		ev(CC);
		rd(FL, 32'hC);
		wr(FL, 32'hF);
		wr(CM, 4);
		rd(FL, 1);
		for (int k = 0; k < 4; k++) begin
			wr(FL, 32'hF);
			ev(drc[k]);
			rd(FL, 1);
			rd(ST, 2);
		end
		is_base <= 1'b0;
		wr(FL, 32'hF);
		ev(RP);
		rd(FL, 0);
		is_base <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			lf = lfsr(lf);
			wr(32'h20, lf);
			rd(32'h20, 0);
			wr(CF, lf & 32'h22);
			rd(CF, lf & 32'h22);
		end
		wr(CF, 0);
		ev(BAL);
		rd(ST, 2);
		for (int k = 0; k < 4; k++) begin
			up();
			if (k == 3) wr(CF, 32'h20);
			ev(sdc[k]);
			rd(ST, 0);
		end
		up();
		wr(CF, 32'h4);
		wr(CM, 2);
		rd(ST, 1);
		// A low enable must freeze the sleep timer
		ce <= 1'b0;
		repeat (SL + 4) @(posedge clk);
		ce <= 1'b1;
		rd(ST, 1);
		repeat (SL + 4) @(posedge clk);
		rd(ST, 0);
		up();
		wr(CF, 32'h3);
		repeat (6) ev(LV);
		rd(ST, 2);
		repeat (ID + 4) @(posedge clk);
		rd(ST, 0);
		up();
		wr(CF, 32'h1);
		repeat (ID + 4) @(posedge clk);
		rd(ST, 1);
		for (int j = 0; j < 2; j++) begin
			up();
			wr(CF, 32'h20);
			ev(j == 0 ? (HP | WP) : HT);
			rd(ST, 32'h7);
			pw(3'b100);
			repeat (HW + 4) @(posedge clk);
			rd(ST, 0);
			rd(CF, 0);
			pw(3'b000);
		end
		repeat (2) @(posedge clk);
		chk("fwd_wake", n_fw, x_fw);
		chk("fwd_resume", n_fr, x_fr);
		chk("heartbeat", n_hb, 1);
		chk("fault_tone", n_ft, 2);
		give_verdict();
	end
endmodule : power_mode_reset_controller_tb
